// file: src/ppl_pkg.sv
package ppl_pkg;

  // ----------------------------------------------------------------
  // Port layout
  // ----------------------------------------------------------------
  localparam int NUM_PORTS  = 9;
  localparam int NUM_LINES  = 73;
  localparam int PORT_MAX_W = 16;
  localparam int ADDR_W     = 12;
  // Widths of the ports in order; entries 4 and 8 are input-only.
  localparam int PORT_W [NUM_PORTS]       = '{8, 8, 13, 4, 11, 3, 5, 16, 5};
  localparam bit PORT_IN_ONLY [NUM_PORTS] = '{0, 0, 0, 0, 1, 0, 0, 0, 1};

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PORT_STRIDE = 12'h010;
  localparam logic [3:0]        OFS_OUT     = 4'h0;
  localparam logic [3:0]        OFS_IN      = 4'h4;
  localparam logic [3:0]        OFS_SET     = 4'h8;
  localparam logic [3:0]        OFS_CLR     = 4'hc;
  localparam logic [ADDR_W-1:0] CFG_BASE    = 12'h100;
  localparam logic [ADDR_W-1:0] BIT_BASE    = 12'h400;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Line configuration word
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       alt_en;
    logic [1:0] drive;
    logic [1:0] slew;
    logic       pull_up;
    logic       pull_en;
    logic       open_drain;
    logic       dir_out;
  } ppl_cfg_t;

  localparam int       CFG_W     = 9;
  localparam ppl_cfg_t CFG_RESET = 9'h000;

  // First flat line index of a port.
  function automatic int port_base(input int p);
    int acc;
    acc = 0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (i < p) begin
        acc = acc + PORT_W[i];
      end
    end
    return acc;
  endfunction

  // True when a flat line belongs to an input-only port.
  function automatic bit line_in_only(input int l);
    bit r;
    r = 1'b0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (l >= port_base(i) && l < port_base(i) + PORT_W[i]) begin
        r = PORT_IN_ONLY[i];
      end
    end
    return r;
  endfunction

endpackage

// file: src/ppl_cell.sv
`timescale 1ns/100ps
module ppl_cell #(
  parameter bit INPUT_ONLY = 1'b0
) (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Settings and software value.
  input  wire ppl_pkg::ppl_cfg_t cfg,
  input  wire logic              out_val,
  // Alternate function side.
  input  wire logic              alt_out,
  input  wire logic              alt_oe,
  // Pad side.
  input  wire logic              pad_i,
  output logic                   pad_o,
  output logic                   pad_oe,
  output logic                   pad_pull_en,
  output logic                   pad_pull_up,
  output logic [1:0]             pad_slew,
  output logic [1:0]             pad_drive,
  output logic                   in_sync
);
  import ppl_pkg::*;

  logic in_meta;
  logic drv_val;
  logic drv_en;

  // Pick the value source and whether the driver may be on at all.
  always_comb begin
    drv_val = cfg.alt_en ? alt_out : out_val;
    drv_en  = !INPUT_ONLY && cfg.dir_out && (!cfg.alt_en || alt_oe);
  end

  // Register the pad controls; open drain only ever pulls low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_o       <= 1'b0;
      pad_oe      <= 1'b0;
      pad_pull_en <= 1'b0;
      pad_pull_up <= 1'b0;
      pad_slew    <= 2'h0;
      pad_drive   <= 2'h0;
    end else begin
      pad_o       <= cfg.open_drain ? 1'b0 : drv_val;
      pad_oe      <= drv_en && (!cfg.open_drain || !drv_val);
      pad_pull_en <= cfg.pull_en;
      pad_pull_up <= cfg.pull_up;
      pad_slew    <= INPUT_ONLY ? 2'h0 : cfg.slew;
      pad_drive   <= INPUT_ONLY ? 2'h0 : cfg.drive;
    end
  end

  // Two-stage synchroniser for the pad level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
    end else begin
      in_meta <= pad_i;
      in_sync <= in_meta;
    end
  end

endmodule

// file: src/ppl_top.sv
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
module ppl_top (
  // Clock and reset.
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [ppl_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [ppl_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // Alternate peripheral functions.
  input  wire logic [ppl_pkg::NUM_LINES-1:0]  alt_out,
  input  wire logic [ppl_pkg::NUM_LINES-1:0]  alt_oe,
  output logic [ppl_pkg::NUM_LINES-1:0]       alt_in,
  // Pads.
  input  wire logic [ppl_pkg::NUM_LINES-1:0]  pad_i,
  output logic [ppl_pkg::NUM_LINES-1:0]       pad_o,
  output logic [ppl_pkg::NUM_LINES-1:0]       pad_oe,
  output logic [ppl_pkg::NUM_LINES-1:0]       pad_pull_en,
  output logic [ppl_pkg::NUM_LINES-1:0]       pad_pull_up,
  output logic [2*ppl_pkg::NUM_LINES-1:0]     pad_slew,
  output logic [2*ppl_pkg::NUM_LINES-1:0]     pad_drive
);
  import ppl_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NUM_LINES-1:0] out_q;
  logic [NUM_LINES-1:0] next_out;
  logic [NUM_LINES-1:0] in_q;
  ppl_cfg_t             cfg_q [NUM_LINES];
  ppl_cfg_t             next_cfg;
  logic [ADDR_W-1:0]    aw_addr;
  logic                 aw_held;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 w_held;
  logic                 wr_fire;
  logic                 wr_ok;
  logic                 cfg_hit;
  int                   cfg_line;
  logic [31:0]          rd_data;
  logic                 rd_ok;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign alt_in  = in_q;

  // ----------------------------------------------------------------
  // Line cells
  // ----------------------------------------------------------------
  // One cell per line; input-only lines get cells without drivers.
  generate
    for (genvar l = 0; l < NUM_LINES; l++) begin : g_line
      ppl_cell #(
        .INPUT_ONLY (line_in_only(l))
      ) u_cell (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .cfg         (cfg_q[l]),
        .out_val     (out_q[l]),
        .alt_out     (alt_out[l]),
        .alt_oe      (alt_oe[l]),
        .pad_i       (pad_i[l]),
        .pad_o       (pad_o[l]),
        .pad_oe      (pad_oe[l]),
        .pad_pull_en (pad_pull_en[l]),
        .pad_pull_up (pad_pull_up[l]),
        .pad_slew    (pad_slew[2*l +: 2]),
        .pad_drive   (pad_drive[2*l +: 2]),
        .in_sync     (in_q[l])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data are taken independently and held until used.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Decode a held write into new output latches or a new line setting.
  always_comb begin
    int p;
    int l;
    int off;
    p        = int'(aw_addr / PORT_STRIDE);
    off      = 0;
    l        = 0;
    next_out = out_q;
    next_cfg = CFG_RESET;
    wr_ok    = 1'b0;
    cfg_hit  = 1'b0;
    cfg_line = 0;
    if (aw_addr < CFG_BASE) begin
      if (p < NUM_PORTS) begin
        wr_ok = (aw_addr[3:0] != OFS_IN);
        off   = port_base(p);
        for (int b = 0; b < PORT_MAX_W; b++) begin
          if (b < PORT_W[p] && !PORT_IN_ONLY[p] && w_strb[b/8]) begin
            case (aw_addr[3:0])
              OFS_OUT: next_out[off+b] = w_data[b];
              OFS_SET: next_out[off+b] = out_q[off+b] | w_data[b];
              OFS_CLR: next_out[off+b] = out_q[off+b] & ~w_data[b];
              default: next_out[off+b] = out_q[off+b];
            endcase
          end
        end
      end
    end else if (aw_addr < BIT_BASE) begin
      l = int'((aw_addr - CFG_BASE) >> 2);
      if (l < NUM_LINES) begin
        wr_ok    = 1'b1;
        cfg_hit  = 1'b1;
        cfg_line = l;
        next_cfg = cfg_q[l];
        if (w_strb[0]) begin
          next_cfg[7:0] = w_data[7:0];
        end
        if (w_strb[1]) begin
          next_cfg.alt_en = w_data[CFG_W-1];
        end
      end
    end else begin
      l = int'((aw_addr - BIT_BASE) >> 2);
      if (l < NUM_LINES) begin
        wr_ok = 1'b1;
        if (w_strb[0] && !line_in_only(l)) begin
          next_out[l] = w_data[0];
        end
      end
    end
  end

  // Output latches, updated only by a completed write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= '0;
    end else if (wr_fire) begin
      out_q <= next_out;
    end
  end

  // Line settings; reset leaves every line an input with pulls off.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int l = 0; l < NUM_LINES; l++) begin
        cfg_q[l] <= CFG_RESET;
      end
    end else if (wr_fire && cfg_hit) begin
      cfg_q[cfg_line] <= next_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Read decode: port words, setting words and single-bit words.
  always_comb begin
    int p;
    int l;
    int off;
    p       = int'(s_axi_araddr / PORT_STRIDE);
    l       = 0;
    off     = 0;
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b0;
    if (s_axi_araddr < CFG_BASE) begin
      if (p < NUM_PORTS) begin
        rd_ok = 1'b1;
        off   = port_base(p);
        for (int b = 0; b < PORT_MAX_W; b++) begin
          if (b < PORT_W[p]) begin
            case (s_axi_araddr[3:0])
              OFS_OUT: rd_data[b] = out_q[off+b];
              OFS_IN:  rd_data[b] = in_q[off+b];
              default: rd_data[b] = 1'b0;
            endcase
          end
        end
      end
    end else if (s_axi_araddr < BIT_BASE) begin
      l = int'((s_axi_araddr - CFG_BASE) >> 2);
      if (l < NUM_LINES) begin
        rd_ok              = 1'b1;
        rd_data[CFG_W-1:0] = cfg_q[l];
      end
    end else begin
      l = int'((s_axi_araddr - BIT_BASE) >> 2);
      if (l < NUM_LINES) begin
        rd_ok      = 1'b1;
        rd_data[0] = in_q[l];
      end
    end
  end

  // One read at a time; the answer follows the address by one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// file: tb/ppl_board.sv
`timescale 1ns/100ps
module ppl_board (
  // Clock.
  input  wire logic                          aclk,
  // Pad controls from the design.
  input  wire logic [ppl_pkg::NUM_LINES-1:0] pad_o,
  input  wire logic [ppl_pkg::NUM_LINES-1:0] pad_oe,
  input  wire logic [ppl_pkg::NUM_LINES-1:0] pad_pull_en,
  input  wire logic [ppl_pkg::NUM_LINES-1:0] pad_pull_up,
  // Board sources.
  input  wire logic [ppl_pkg::NUM_LINES-1:0] ext_en,
  input  wire logic [ppl_pkg::NUM_LINES-1:0] ext_v,
  // Resolved wire level.
  output logic      [ppl_pkg::NUM_LINES-1:0] pad_i
);
  import ppl_pkg::*;
  logic [NUM_LINES-1:0] last = '0;
  // Driver wins, then the board, then the pull; a bare wire drifts every cycle.
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_v)
               | (~pad_oe & ~ext_en & pad_pull_en & pad_pull_up)
               | (~pad_oe & ~ext_en & ~pad_pull_en & ~last);
  // Remember the level so a floating wire flips.
  always_ff @(posedge aclk) begin
    last <= pad_i;
  end
endmodule

// file: tb/ppl_top_assertions.sv
`timescale 1ns/100ps
module ppl_top_assertions (
  // Clock and reset.
  input wire logic                            aclk,
  input wire logic                            aresetn,
  // Bus handshakes.
  input wire logic                            s_axi_awvalid,
  input wire logic                            s_axi_awready,
  input wire logic                            s_axi_wvalid,
  input wire logic                            s_axi_wready,
  input wire logic [1:0]                      s_axi_bresp,
  input wire logic                            s_axi_bvalid,
  input wire logic                            s_axi_bready,
  input wire logic                            s_axi_arvalid,
  input wire logic                            s_axi_arready,
  input wire logic [31:0]                     s_axi_rdata,
  input wire logic                            s_axi_rvalid,
  input wire logic                            s_axi_rready,
  // Pads.
  input wire logic [ppl_pkg::NUM_LINES-1:0]   pad_i,
  input wire logic [ppl_pkg::NUM_LINES-1:0]   alt_in,
  input wire logic [ppl_pkg::NUM_LINES-1:0]   pad_oe,
  input wire logic [ppl_pkg::NUM_LINES-1:0]   pad_pull_en,
  input wire logic [2*ppl_pkg::NUM_LINES-1:0] pad_slew,
  input wire logic [2*ppl_pkg::NUM_LINES-1:0] pad_drive
);
  import ppl_pkg::*;
  localparam logic [72:0]  IN_ONLY = {5'h1f, 24'h0, 11'h7ff, 33'h0};
  localparam logic [145:0] SD_MASK = {10'h3ff, 48'h0, 22'h3fffff, 66'h0};
  logic [1:0] age;
  // Counts edges since reset release, so the synchroniser has filled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  a_rd_answer: assert property (s_rd_take |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_inonly_float: assert property ((pad_oe & IN_ONLY) == '0)
    else $error("input-only line driven");
  a_inonly_shape: assert property (((pad_slew | pad_drive) & SD_MASK) == '0)
    else $error("input-only line shaped");
  a_alt_sync: assert property (age == 2'h3 |-> alt_in == $past(pad_i, 2))
    else $error("peripheral input wrong");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    pad_oe == '0 && pad_pull_en == '0)
    else $error("pad active in reset");
endmodule
bind ppl_top ppl_top_assertions ppl_top_assertions_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pad_i,
  .alt_in, .pad_oe, .pad_pull_en, .pad_slew, .pad_drive);

// file: tb/test_parallel_port_lines.sv
`timescale 1ns/100ps
module test_parallel_port_lines;
  import ppl_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [72:0] alt_out = 0, alt_oe = 0, ext_v = {5'h15, 68'h0}, ext_en = ~73'h8;
  logic [72:0] alt_in, pad_i, pad_o, pad_oe, pad_pull_en, pad_pull_up;
  logic [145:0] pad_slew, pad_drive;
  int mismatches = 0, n_checks = 0, cycles = 0;
  ppl_top ppl_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alt_out, .alt_oe, .alt_in, .pad_i,
    .pad_o, .pad_oe, .pad_pull_en, .pad_pull_up, .pad_slew, .pad_drive);
  ppl_board ppl_board_i (.aclk, .pad_o, .pad_oe, .pad_pull_en, .pad_pull_up, .ext_en,
    .ext_v, .pad_i);
  // 200 MHz clock.
  always #2.5 aclk = ~aclk;
  // Cuts a hang short.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  // Write one word and compare the response code.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  // Read one word and compare data and response code.
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic cfg(input int l, input logic [31:0] v);
    wr(CFG_BASE + 12'(4 * l), v, RESP_OKAY);
  endtask
  // Main sequence.
  initial begin
    repeat (12) @(posedge aclk);
    chk(32'(|{pad_oe, pad_pull_en}), 32'h0);
    aresetn <= 1'b1;
    rd(CFG_BASE, 32'h0, RESP_OKAY);
    for (int l = 0; l < 8; l++) cfg(l, 32'h001);
    wr(12'h000, 32'h5a, RESP_OKAY);
    tick(2);
    chk(32'(pad_oe[7:0]), 32'hff);
    chk(32'(pad_o[7:0]), 32'h5a);
    wr(BIT_BASE + 12'h004, 32'h0, RESP_OKAY);
    wr(12'h008, 32'h1, RESP_OKAY);
    wr(12'h00c, 32'h8, RESP_OKAY);
    rd(12'h000, 32'h51, RESP_OKAY);
    cfg(2, 32'h003);
    tick(2);
    chk(32'({pad_oe[2], pad_o[2]}), 32'h2);
    wr(12'h008, 32'h4, RESP_OKAY);
    cfg(3, 32'h00c);
    tick(4);
    chk(32'({pad_oe[3:2], pad_pull_en[3], pad_pull_up[3]}), 32'h3);
    rd(12'h004, 32'h59, RESP_OKAY);
    cfg(4, 32'h0e1);
    tick(2);
    chk(32'({pad_slew[9:8], pad_drive[9:8]}), 32'hb);
    cfg(5, 32'h101);
    @(posedge aclk);
    alt_out[5] <= 1'b1;
    alt_oe[5] <= 1'b1;
    tick(5);
    chk(32'({pad_oe[5], pad_o[5], alt_in[5]}), 32'h7);
    @(posedge aclk);
    alt_oe[5] <= 1'b0;
    tick(5);
    chk(32'({pad_oe[5], alt_in[5]}), 32'h0);
    cfg(33, 32'h0e5);
    tick(2);
    chk(32'({pad_oe[33], pad_slew[67:66], pad_drive[67:66], pad_pull_en[33]}), 32'h1);
    wr(12'h040, 32'hffff, RESP_OKAY);
    rd(12'h040, 32'h0, RESP_OKAY);
    wr(12'h070, 32'h1ffff, RESP_OKAY);
    rd(12'h070, 32'hffff, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    wr(12'h070, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(12'h070, 32'hff00, RESP_OKAY);
    rd(12'h084, 32'h15, RESP_OKAY);
    wr(12'h300, 32'h1, RESP_SLVERR);
    wr(12'h004, 32'h0, RESP_SLVERR);
    rd(12'h300, 32'h0, RESP_SLVERR);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(|{pad_oe, pad_pull_en}), 32'h0);
    aresetn <= 1'b1;
    rd(CFG_BASE + 12'h010, 32'h0, RESP_OKAY);
    close_out();
  end
endmodule
